// [rtl/emi_regs.svh]
// Purpose: register offsets, field positions and timing counts
// Assumes: included by the sequencer, the top level, the checker and the bench
// Notes: offsets are special-function-register addresses
`ifndef EMI_REGS_SVH
`define EMI_REGS_SVH
`define EMI_SFR_CONFIG 8'ha3
`define EMI_SFR_PAGE 8'ha2
`define EMI_SFR_PTRL 8'ha4
`define EMI_SFR_PTRH 8'ha5
`define EMI_CFG_RESET 6'h03
`define EMI_PAGE_RESET 8'h00
`define EMI_DP_RESET 8'h00
`define EMI_CFG_W 6
`define EMI_CFG_PORT_BIT 5
`define EMI_CFG_MUX_BIT 4
`define EMI_CFG_MODE_HI 3
`define EMI_CFG_MODE_LO 2
`define EMI_CFG_ALE_HI 1
`define EMI_CFG_ALE_LO 0
`define EMI_ONCHIP_TOP 16'h1000
`define EMI_ALE_BASE 3'h1
`define EMI_SETUP_LAST 4'h0
`define EMI_HOLD_LAST 4'h0
`define EMI_PORTS_PER_GRP 4
`define EMI_ROLE_CTRL 0
`define EMI_ROLE_ALO 1
`define EMI_ROLE_AHI 2
`define EMI_ROLE_DATA 3
`define EMI_PIN_WR 7
`define EMI_PIN_RD 6
`define EMI_PIN_ALE 5
`define EMI_DATA_LO_BIT 24
`define EMI_DATA_HI_BIT 56
`endif

// [rtl/emi_pkg.sv]
// Purpose: shared types of the external memory interface
// Assumes: nothing
// Notes: state codes are one-hot
package emi_pkg;
    typedef enum logic [1:0] {
        emi_mode_onchip = 2'h0,
        emi_mode_split_nb = 2'h1,
        emi_mode_split_bs = 2'h2,
        emi_mode_offchip = 2'h3
    } emi_mode_t;
    typedef enum logic [2:0] {
        emi_top_idle = 3'h1,
        emi_top_ram = 3'h2,
        emi_top_ext = 3'h4
    } emi_top_st_t;
    typedef enum logic [4:0] {
        emi_bus_idle = 5'h01,
        emi_bus_ale = 5'h02,
        emi_bus_setup = 5'h04,
        emi_bus_strobe = 5'h08,
        emi_bus_hold = 5'h10
    } emi_bus_st_t;
    typedef struct packed {
        logic [15:0] addr;
        logic hi_oe;
        logic wr;
        logic mux;
        logic [2:0] ale_cyc;
        logic [7:0] wdata;
    } emi_xreq_t;
    typedef struct packed {
        logic active;
        logic mux;
        logic hi_oe;
        logic [15:0] addr;
        logic [7:0] ad;
        logic ad_oe;
        logic rd_n;
        logic wr_n;
        logic ale;
    } emi_bus_t;
endpackage

// [rtl/emi_onchip_ext_ram.sv]
// Purpose: on-chip data RAM behind the external-move path
// Assumes: one request pulse at a time
// Notes: answer one cycle after the request
`timescale 1ns/10ps
`default_nettype none
module emi_lram #(
    parameter int AW = 12
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // request
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    // answer
    output logic ack_o,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge core_clk_i) begin
        if (ce_i && req_i && we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_o <= 1'b0;
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            ack_o <= req_i;
            if (req_i && !we_i) begin
                rdata_o <= mem[addr_i];
            end
        end
    end
endmodule // emi_lram
`default_nettype wire

// [rtl/emi_xbus.sv]
// Purpose: off-chip strobe sequencer
// Assumes: pin_data_i already synchronised
// Notes: read data is taken in the hold cycle
`timescale 1ns/10ps
`default_nettype none
`include "emi_regs.svh"
module emi_xbus #(
    parameter int STROBE_CYC = 3
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // request
    input wire logic start_i,
    input wire emi_pkg::emi_xreq_t req_i,
    input wire logic [7:0] pin_data_i,
    // answer
    output var emi_pkg::emi_bus_t bus_o,
    output logic done_o,
    output logic [7:0] rdata_o
);
    localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
    emi_pkg::emi_bus_st_t state_r, state_nxt;
    emi_pkg::emi_xreq_t req_r;
    logic [3:0] cnt_r, cnt_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            emi_pkg::emi_bus_idle: if (start_i) begin
                state_nxt = req_i.mux ? emi_pkg::emi_bus_ale
                                      : emi_pkg::emi_bus_setup;
            end
            emi_pkg::emi_bus_ale:
                if (cnt_r == {1'b0, req_r.ale_cyc} - 4'h1) begin
                    state_nxt = emi_pkg::emi_bus_setup;
                end
            emi_pkg::emi_bus_setup: if (cnt_r == `EMI_SETUP_LAST) begin
                state_nxt = emi_pkg::emi_bus_strobe;
            end
            emi_pkg::emi_bus_strobe: if (cnt_r == STROBE_LAST) begin
                state_nxt = emi_pkg::emi_bus_hold;
            end
            emi_pkg::emi_bus_hold: if (cnt_r == `EMI_HOLD_LAST) begin
                state_nxt = emi_pkg::emi_bus_idle;
            end
            default: state_nxt = emi_pkg::emi_bus_idle;
        endcase
        cnt_nxt = (state_nxt != state_r) ? 4'h0 : cnt_r + 4'h1;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= emi_pkg::emi_bus_idle;
            cnt_r <= 4'h0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_r <= '0;
        end else if (ce_i && start_i && state_r == emi_pkg::emi_bus_idle) begin
            req_r <= req_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_o <= 1'b0;
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            done_o <= (state_r == emi_pkg::emi_bus_hold) &&
                      (state_nxt == emi_pkg::emi_bus_idle);
            if (state_r == emi_pkg::emi_bus_hold && !req_r.wr) begin
                rdata_o <= pin_data_i;
            end
        end
    end

    always_comb begin
        bus_o.active = state_r != emi_pkg::emi_bus_idle;
        bus_o.mux = req_r.mux;
        bus_o.hi_oe = req_r.hi_oe;
        bus_o.addr = req_r.addr;
        bus_o.ale = state_r == emi_pkg::emi_bus_ale;
        bus_o.ad = bus_o.ale ? req_r.addr[7:0] : req_r.wdata;
        // drivers stay off on data lines that act as inputs
        bus_o.ad_oe = bus_o.active && (bus_o.ale || req_r.wr);
        bus_o.rd_n = !(state_r == emi_pkg::emi_bus_strobe && !req_r.wr);
        bus_o.wr_n = !(state_r == emi_pkg::emi_bus_strobe && req_r.wr);
    end
endmodule // emi_xbus
`default_nettype wire

// [rtl/emi_top.sv]
// Purpose: external data memory interface, address and pin control
// Assumes: cpu and special-function bus on core_clk_i
// Notes: pins are reported as value, enable and claim per bit
`timescale 1ns/10ps
`default_nettype none
`include "emi_regs.svh"
module emi_top #(
    parameter int STROBE_CYC = 3,
    parameter int RAM_AW = 12
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // special-function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // external-move requests from the cpu
    input wire logic xmov_req_i,
    input wire logic xmov_wr_i,
    input wire logic xmov_wide_i,
    input wire logic xmov_idx_sel_i,
    input wire logic [7:0] index_reg_zero_i,
    input wire logic [7:0] index_reg_one_i,
    input wire logic [7:0] xmov_wdata_i,
    output logic xmov_busy_o,
    output logic xmov_done_o,
    output logic [7:0] xmov_rdata_o,
    // general-purpose port pins, eight ports of eight
    input wire logic [63:0] port_pin_i,
    output logic [63:0] port_pin_o,
    output logic [63:0] port_pin_oe_o,
    output logic [63:0] port_claim_o
);
    if (STROBE_CYC < 3 || STROBE_CYC > 15) begin : g_bad_strobe
        $error("STROBE_CYC must lie in 3..15");
    end
    if (RAM_AW < 1 || RAM_AW > 16) begin : g_bad_ram
        $error("RAM_AW must lie in 1..16");
    end

    // configuration and pointer registers
    logic [`EMI_CFG_W-1:0] cfg_r;
    logic [7:0] page_r;
    logic [7:0] ptrh_r;
    logic [7:0] ptrl_r;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_r <= `EMI_CFG_RESET;
            page_r <= `EMI_PAGE_RESET;
            ptrh_r <= `EMI_DP_RESET;
            ptrl_r <= `EMI_DP_RESET;
        end else if (ce_i && sfr_wr_i) begin
            unique case (sfr_addr_i)
                `EMI_SFR_CONFIG: cfg_r <= sfr_wdata_i[`EMI_CFG_W-1:0];
                `EMI_SFR_PAGE: page_r <= sfr_wdata_i;
                `EMI_SFR_PTRH: ptrh_r <= sfr_wdata_i;
                `EMI_SFR_PTRL: ptrl_r <= sfr_wdata_i;
                default: ;
            endcase
        end
    end

    function automatic logic [7:0] sfr_read(input logic [7:0] a,
                                            input logic [`EMI_CFG_W-1:0] c,
                                            input logic [7:0] pg,
                                            input logic [7:0] dh,
                                            input logic [7:0] dl);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            `EMI_SFR_CONFIG: r = {2'h0, c};
            `EMI_SFR_PAGE: r = pg;
            `EMI_SFR_PTRH: r = dh;
            `EMI_SFR_PTRL: r = dl;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (ce_i && sfr_rd_i) begin
            sfr_rdata_o <= sfr_read(sfr_addr_i, cfg_r, page_r, ptrh_r, ptrl_r);
        end
    end

    // configuration fields
    logic port_sel;
    logic mux_sel;
    emi_pkg::emi_mode_t mode;
    logic [2:0] ale_cyc;

    assign port_sel = cfg_r[`EMI_CFG_PORT_BIT];
    assign mux_sel = !cfg_r[`EMI_CFG_MUX_BIT];
    assign mode = emi_pkg::emi_mode_t'(
        cfg_r[`EMI_CFG_MODE_HI:`EMI_CFG_MODE_LO]);
    // width in cycles is field plus one, reset gives four
    assign ale_cyc = {1'b0, cfg_r[`EMI_CFG_ALE_HI:`EMI_CFG_ALE_LO]}
                     + `EMI_ALE_BASE;

    // effective address of the request being offered
    logic [7:0] idx_byte;
    logic [15:0] eff_addr;
    logic go_onchip;
    logic hi_drive;

    assign idx_byte = xmov_idx_sel_i ? index_reg_one_i
                                     : index_reg_zero_i;
    assign eff_addr = xmov_wide_i ? {ptrh_r, ptrl_r}
                                  : {page_r, idx_byte};

    always_comb begin
        unique case (mode)
            // reset mode keeps everything on-chip
            emi_pkg::emi_mode_onchip: go_onchip = 1'b1;
            emi_pkg::emi_mode_split_nb,
            emi_pkg::emi_mode_split_bs:
                go_onchip = eff_addr < `EMI_ONCHIP_TOP;
            emi_pkg::emi_mode_offchip: go_onchip = 1'b0;
        endcase
    end

    // 8-bit form drives the high byte only with bank select
    assign hi_drive = xmov_wide_i ||
                      (mode == emi_pkg::emi_mode_split_bs);

    // request sequencing
    emi_pkg::emi_top_st_t state_r;
    logic busy_r;
    logic xmov_wr_r;
    logic accept;
    logic ram_ack;
    logic [7:0] ram_rdata;
    logic xb_done;
    logic [7:0] xb_rdata;
    emi_pkg::emi_xreq_t xreq;
    emi_pkg::emi_bus_t xb_bus;

    assign accept = ce_i && xmov_req_i && !busy_r;
    assign xreq.addr = eff_addr;
    assign xreq.hi_oe = hi_drive;
    assign xreq.wr = xmov_wr_i;
    assign xreq.mux = mux_sel;
    assign xreq.ale_cyc = ale_cyc;
    assign xreq.wdata = xmov_wdata_i;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= emi_pkg::emi_top_idle;
        end else if (ce_i) begin
            unique case (state_r)
                emi_pkg::emi_top_idle: if (accept) begin
                    state_r <= go_onchip ? emi_pkg::emi_top_ram
                                         : emi_pkg::emi_top_ext;
                end
                emi_pkg::emi_top_ram: if (ram_ack) begin
                    state_r <= emi_pkg::emi_top_idle;
                end
                emi_pkg::emi_top_ext: if (xb_done) begin
                    state_r <= emi_pkg::emi_top_idle;
                end
                default: state_r <= emi_pkg::emi_top_idle;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_r <= 1'b0;
            xmov_done_o <= 1'b0;
            xmov_rdata_o <= 8'h00;
        end else if (ce_i) begin
            xmov_done_o <= ram_ack || xb_done;
            if (accept) begin
                busy_r <= 1'b1;
            end else if (ram_ack || xb_done) begin
                busy_r <= 1'b0;
            end
            if (ram_ack && !xmov_wr_r) begin
                xmov_rdata_o <= ram_rdata;
            end else if (xb_done && !xmov_wr_r) begin
                xmov_rdata_o <= xb_rdata;
            end
        end
    end

    // direction of the move in flight
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            xmov_wr_r <= 1'b0;
        end else if (accept) begin
            xmov_wr_r <= xmov_wr_i;
        end
    end

    assign xmov_busy_o = busy_r;

    // on-chip RAM, address wraps on its own size
    emi_lram #(
        .AW(RAM_AW)
    ) u_lram (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .req_i(accept && go_onchip),
        .we_i(xmov_wr_i),
        .addr_i(eff_addr[RAM_AW-1:0]),
        .wdata_i(xmov_wdata_i),
        .ack_o(ram_ack),
        .rdata_o(ram_rdata)
    );

    // data pins of both groups pass two stages before use
    logic [15:0] din_s1_r;
    logic [15:0] din_s2_r;
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            din_s1_r <= 16'h0000;
            din_s2_r <= 16'h0000;
        end else if (ce_i) begin
            din_s1_r <= {port_pin_i[`EMI_DATA_HI_BIT +: 8],
                         port_pin_i[`EMI_DATA_LO_BIT +: 8]};
            din_s2_r <= din_s1_r;
        end
    end

    emi_xbus #(
        .STROBE_CYC(STROBE_CYC)
    ) u_xbus (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .start_i(accept && !go_onchip),
        .req_i(xreq),
        .pin_data_i(port_sel ? din_s2_r[15:8] : din_s2_r[7:0]),
        .bus_o(xb_bus),
        .done_o(xb_done),
        .rdata_o(xb_rdata)
    );

    // pin roles within a group of four ports
    function automatic logic [7:0] role_claim(input int role,
                                              input emi_pkg::emi_bus_t b);
        logic [7:0] m;
        m = 8'h00;
        unique case (role)
            `EMI_ROLE_CTRL: begin
                // strobes always claimed, latch pin claimed only when multiplexed
                m[`EMI_PIN_WR] = 1'b1;
                m[`EMI_PIN_RD] = 1'b1;
                m[`EMI_PIN_ALE] = b.mux;
            end
            `EMI_ROLE_ALO: m = b.mux ? 8'h00 : 8'hff;
            `EMI_ROLE_AHI: m = b.hi_oe ? 8'hff : 8'h00;
            default: m = 8'hff;
        endcase
        return m;
    endfunction

    function automatic logic [7:0] role_val(input int role,
                                            input emi_pkg::emi_bus_t b);
        logic [7:0] v;
        v = 8'h00;
        unique case (role)
            `EMI_ROLE_CTRL: begin
                v[`EMI_PIN_WR] = b.wr_n;
                v[`EMI_PIN_RD] = b.rd_n;
                v[`EMI_PIN_ALE] = b.ale;
            end
            `EMI_ROLE_ALO: v = b.addr[7:0];
            `EMI_ROLE_AHI: v = b.addr[15:8];
            default: v = b.ad;
        endcase
        return v;
    endfunction

    logic [63:0] clm_w;
    logic [63:0] oe_w;
    logic [63:0] val_w;

    for (genvar p = 0; p < 8; p++) begin : g_port
        localparam int GRP = p / `EMI_PORTS_PER_GRP;
        localparam int ROLE = p % `EMI_PORTS_PER_GRP;
        logic sel;
        logic [7:0] clm;
        // only the chosen group, only while off-chip
        assign sel = xb_bus.active && (GRP[0] == port_sel);
        assign clm = sel ? role_claim(ROLE, xb_bus) : 8'h00;
        assign clm_w[p*8 +: 8] = clm;
        // data lines claimed but undriven when input
        assign oe_w[p*8 +: 8] = (ROLE == `EMI_ROLE_DATA)
                                ? (clm & {8{xb_bus.ad_oe}}) : clm;
        assign val_w[p*8 +: 8] = sel ? role_val(ROLE, xb_bus) : 8'h00;
    end

    // enable means driving; push-pull or open-drain is not set here
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            port_pin_o <= 64'h0;
            port_pin_oe_o <= 64'h0;
            port_claim_o <= 64'h0;
        end else if (ce_i) begin
            port_pin_o <= val_w;
            port_pin_oe_o <= oe_w;
            port_claim_o <= clm_w;
        end
    end
endmodule // emi_top
`default_nettype wire

// [verif/emi_top_checker.sv]
// Purpose: port assertions for the external memory interface
// Assumes: config is not rewritten while a move runs
// Notes: mirrors config, page and ptrh from register writes
`timescale 1ns/10ps
`default_nettype none
`include "emi_regs.svh"
module emi_top_checker #(
    parameter int STROBE_CYC = 3
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    // moves
    input wire logic xmov_req_i,
    input wire logic xmov_wr_i,
    input wire logic xmov_wide_i,
    input wire logic xmov_busy_o,
    input wire logic xmov_done_o,
    // pins
    input wire logic [63:0] port_pin_o,
    input wire logic [63:0] port_pin_oe_o,
    input wire logic [63:0] port_claim_o
);
    localparam int LO = STROBE_CYC + 3;
    localparam int HI = STROBE_CYC + 4;
    logic [5:0] cfg_r;
    logic [7:0] pg_r, ptrh_r;
    logic wr_r, wide_r;
    logic [2:0] ale_cnt_r;
    wire acc = ce_i && xmov_req_i && !xmov_busy_o;
    wire g = cfg_r[5];
    wire [1:0] mode = cfg_r[3:2];
    wire [63:0] act = port_pin_o & port_claim_o;
    wire ale = g ? act[37] : act[5];
    wire [7:0] hi_pin = g ? port_pin_o[55:48] : port_pin_o[23:16];
    wire [7:0] hi_clm = g ? port_claim_o[55:48] : port_claim_o[23:16];
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_r <= `EMI_CFG_RESET;
            pg_r <= 8'h00;
            ptrh_r <= 8'h00;
        end else if (ce_i && sfr_wr_i) begin
            if (sfr_addr_i == `EMI_SFR_CONFIG) cfg_r <= sfr_wdata_i[5:0];
            if (sfr_addr_i == `EMI_SFR_PAGE) pg_r <= sfr_wdata_i;
            if (sfr_addr_i == `EMI_SFR_PTRH) ptrh_r <= sfr_wdata_i;
        end
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_r <= 1'b0;
            wide_r <= 1'b0;
        end else if (acc) begin
            wr_r <= xmov_wr_i;
            wide_r <= xmov_wide_i;
        end
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) ale_cnt_r <= 3'h0;
        else ale_cnt_r <= ale ? ale_cnt_r + 3'h1 : 3'h0;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    claim_idle_a:
        assert property (!xmov_busy_o |-> port_claim_o == 64'h0)
        else $error("pins claimed while idle");
    oe_claim_a:
        assert property ((port_pin_oe_o & ~port_claim_o) == 64'h0)
        else $error("pin driven without claim");
    read_in_a:
        assert property (xmov_busy_o && !wr_r && !ale |->
            (port_pin_oe_o & 64'hff00_0000_ff00_0000) == 64'h0)
        else $error("data pins driven during read");
    onchip_lat_a:
        assert property (acc && mode == 2'h0 |=>
            xmov_busy_o && port_claim_o == 64'h0 ##1 xmov_done_o)
        else $error("on-chip move wrong");
    offchip_lat_a:
        assert property (acc && mode == 2'h3 && cfg_r[4] |->
            ##[LO:HI] xmov_done_o)
        else $error("off-chip move late");
    hi_addr_a:
        assert property (xmov_busy_o && hi_clm == 8'hff |->
            hi_pin == (wide_r ? ptrh_r : pg_r))
        else $error("high address byte wrong");
    hi_free_a:
        assert property (xmov_busy_o && !wide_r && mode[0] |->
            hi_clm == 8'h00)
        else $error("high address lines claimed");
    grp_a:
        assert property (xmov_busy_o |->
            (g ? port_claim_o[31:0] : port_claim_o[63:32]) == 32'h0)
        else $error("wrong port group claimed");
    mux_a:
        assert property (!cfg_r[4] |->
            (port_claim_o & 64'h0000_ff00_0000_ff00) == 64'h0)
        else $error("address low port used in multiplexed mode");
    ale_width_a:
        assert property ($fell(ale) |->
            ale_cnt_r == {1'b0, cfg_r[1:0]} + 3'h1)
        else $error("latch pulse width wrong");
    onchip_c: cover property (acc && mode == 2'h0);
    ale_c: cover property ($fell(ale));
    read_c: cover property (xmov_done_o && !wr_r && mode == 2'h3);
endmodule // emi_top_checker
bind emi_top emi_top_checker #(.STROBE_CYC(STROBE_CYC)) emi_top_checker_i (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .xmov_req_i(xmov_req_i),
    .xmov_wr_i(xmov_wr_i), .xmov_wide_i(xmov_wide_i),
    .xmov_busy_o(xmov_busy_o), .xmov_done_o(xmov_done_o),
    .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o),
    .port_claim_o(port_claim_o)
);
`default_nettype wire

// [verif/emi_far_mem.sv]
// Purpose: off-chip byte memory on the interface pins
// Assumes: pins_i is the resolved pin level
// Notes: cell n starts as n[7:0] ^ n[15:8]
`timescale 1ns/10ps
`default_nettype none
module emi_far_mem (
    // clock
    input wire logic core_clk_i,
    // pins and wiring choice
    input wire logic [63:0] pins_i,
    input wire logic grp_i,
    input wire logic mux_i,
    output logic [63:0] drv_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] lat_r, wbuf_r, dq;
    logic [7:0] idle_r = 8'h00;
    logic wact_r = 1'b0;
    logic [31:0] p;
    logic [15:0] addr;
    // either group carries its strobes and latch on the first of its four ports
    assign p = grp_i ? pins_i[63:32] : pins_i[31:0];
    assign addr = {p[23:16], mux_i ? lat_r : p[15:8]};
    // a released data line flips each cycle
    assign dq = !p[6] ? mem[addr] : idle_r;
    // unclaimed pins outside the chosen group's data port park high
    assign drv_o = grp_i ? {dq, {56{1'b1}}} : {{32{1'b1}}, dq, 24'hffffff};
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i ^ (i >> 8));
        end
    end
    always @(posedge core_clk_i) begin
        idle_r <= ~dq;
        if (p[5]) lat_r <= p[31:24];
        wact_r <= !p[7];
        if (!p[7]) wbuf_r <= p[31:24];
        if (p[7] && wact_r) mem[addr] <= wbuf_r;
    end
endmodule // emi_far_mem
`default_nettype wire

// [verif/test_emi_top.sv]
// Purpose: self-checking bench for the memory interface
// Assumes: default strobe count
// Notes: far side is emi_far_mem
`timescale 1ns/10ps
`default_nettype none
`include "emi_regs.svh"
module test_emi_top;
    logic clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic req = 1'b0, wr = 1'b0, wide = 1'b0, sel = 1'b0;
    logic [7:0] sfr_a = 8'h00, sfr_d = 8'h00, idx0 = 8'h00;
    logic [7:0] idx1 = 8'h00, wd = 8'h00, cfg_v = 8'h03;
    logic [7:0] sfr_q, rdata;
    logic busy, done;
    logic [63:0] pin_i, pin_o, oe, drv;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    assign pin_i = (pin_o & oe) | (drv & ~oe);
    emi_top emi_top_i (
        .core_clk_i(clk), .reset_n_i(rst_n), .ce_i(1'b1),
        .sfr_addr_i(sfr_a), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd),
        .sfr_wdata_i(sfr_d), .sfr_rdata_o(sfr_q), .xmov_req_i(req),
        .xmov_wr_i(wr), .xmov_wide_i(wide), .xmov_idx_sel_i(sel),
        .index_reg_zero_i(idx0), .index_reg_one_i(idx1),
        .xmov_wdata_i(wd), .xmov_busy_o(busy), .xmov_done_o(done),
        .xmov_rdata_o(rdata), .port_pin_i(pin_i), .port_pin_o(pin_o),
        .port_pin_oe_o(oe), .port_claim_o()
    );
    emi_far_mem emi_far_mem_i (
        .core_clk_i(clk), .pins_i(pin_i), .grp_i(cfg_v[5]),
        .mux_i(!cfg_v[4]), .drv_o(drv)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_a <= a;
        sfr_d <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic sfr_r(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_a <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(negedge clk);
        chk(sfr_q, exp);
    endtask
    task automatic set_cfg(input logic [7:0] d);
        cfg_v <= d;
        sfr_w(`EMI_SFR_CONFIG, d);
    endtask
    task automatic mx(input logic w, input logic f, input logic s,
                      input logic [7:0] d, input logic [7:0] exp);
        int k;
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        wide <= f;
        sel <= s;
        wd <= d;
        @(posedge clk);
        req <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        if (k == 40) begin
            n_errors++;
            $display("[FAIL] %0t move never finished", $time);
        end
        if (!w) chk(rdata, exp);
    endtask
    task automatic t_regs;
        sfr_r(`EMI_SFR_CONFIG, 8'h03);
        sfr_r(`EMI_SFR_PAGE, 8'h00);
        sfr_r(`EMI_SFR_PTRH, 8'h00);
        sfr_r(`EMI_SFR_PTRL, 8'h00);
        sfr_r(8'ha0, 8'h00);
        sfr_w(`EMI_SFR_CONFIG, 8'hff);
        sfr_r(`EMI_SFR_CONFIG, 8'h3f);
        sfr_w(`EMI_SFR_PTRH, 8'h12);
        sfr_w(`EMI_SFR_PTRL, 8'h34);
        sfr_r(`EMI_SFR_PTRH, 8'h12);
        sfr_r(`EMI_SFR_PTRL, 8'h34);
        $display("test regs done");
    endtask
    task automatic t_onchip;
        set_cfg(8'h03);
        mx(1'b1, 1'b1, 1'b0, 8'h5a, 8'h00);
        sfr_w(`EMI_SFR_PAGE, 8'h02);
        idx0 <= 8'h34;
        mx(1'b0, 1'b0, 1'b0, 8'h00, 8'h5a);
        mx(1'b0, 1'b1, 1'b0, 8'h00, 8'h5a);
        $display("test on-chip done");
    endtask
    task automatic t_offsep;
        set_cfg(8'h1c);
        sfr_w(`EMI_SFR_PTRH, 8'h03);
        sfr_w(`EMI_SFR_PTRL, 8'h45);
        mx(1'b1, 1'b1, 1'b0, 8'ha5, 8'h00);
        chk(emi_far_mem_i.mem[16'h0345], 8'ha5);
        mx(1'b0, 1'b1, 1'b0, 8'h00, 8'ha5);
        idx1 <= 8'h45;
        mx(1'b0, 1'b0, 1'b1, 8'h00, 8'hba);
        $display("test off-chip separate done");
    endtask
    task automatic t_mux;
        set_cfg(8'h29);
        sfr_w(`EMI_SFR_PAGE, 8'h37);
        idx0 <= 8'h12;
        mx(1'b0, 1'b0, 1'b0, 8'h00, 8'h25);
        mx(1'b1, 1'b0, 1'b0, 8'h66, 8'h00);
        chk(emi_far_mem_i.mem[16'h3712], 8'h66);
        for (int f = 0; f < 4; f++) begin
            set_cfg(8'h28 | 8'(f));
            mx(1'b0, 1'b0, 1'b0, 8'h00, 8'h66);
        end
        $display("test multiplexed done");
    endtask
    task automatic t_split;
        set_cfg(8'h14);
        sfr_w(`EMI_SFR_PAGE, 8'h20);
        idx0 <= 8'h0f;
        mx(1'b0, 1'b0, 1'b0, 8'h00, 8'hf0);
        sfr_w(`EMI_SFR_PAGE, 8'h02);
        idx0 <= 8'h34;
        mx(1'b0, 1'b0, 1'b0, 8'h00, 8'h5a);
        $display("test split done");
    endtask
    task automatic print_verdict;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            $display("[FAIL] %0t run did not finish", $time);
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_onchip();
        t_offsep();
        t_mux();
        t_split();
        print_verdict();
    end
endmodule // test_emi_top
`default_nettype wire
